// ==== bsadc_pkg.sv ====
// Shared constants for the scan chain and its converter check
package bsadc_pkg;

	localparam int CHAIN_LEN = 205;

	// Chain positions, bit 0 nearest the serial output
	localparam int BIT_COMP_IDLE = 204;
	localparam int BIT_ACO = 203;
	localparam int BIT_MUX_NEG = 202;
	localparam int BIT_BG_POS = 201;
	localparam int BIT_COMP = 200;
	localparam int BIT_CONV_EN = 194;
	localparam int BIT_DAC_MSB = 192;
	localparam int BIT_DAC_LSB = 183;
	localparam int BIT_HOLD = 178;
	localparam int BIT_CHSEL_MSB = 176;
	localparam int BIT_CHSEL_LSB = 169;
	localparam int BIT_NEG_MSB = 166 + 2;
	localparam int BIT_NEG_LSB = 166;
	localparam int BIT_GAIN_PASSGATE_ENABLE = 165;
	localparam int BIT_LATCH_PRECHARGE_N_N = 164;
	localparam int BIT_PROG_OBS = 160;
	localparam int PORTE_BASE = 159;
	localparam int PORTC_BASE = 62;
	localparam int PORTA_BASE = 35;
	localparam int CELLS_PER_PIN = 3;
	localparam int PORTE_PINS = 6;
	localparam int PORTC_TAP_LO = 2;
	localparam int PORTC_TAP_HI = 5;

	localparam logic [CHAIN_LEN-1:0] ONE = {{(CHAIN_LEN-1){1'b0}}, 1'b1};
	// Recommended idle values of the converter cells
	localparam logic [CHAIN_LEN-1:0] IDLE_CELLS = (ONE << BIT_HOLD) | (ONE << BIT_CHSEL_LSB)
		| (ONE << BIT_GAIN_PASSGATE_ENABLE) | (ONE << BIT_LATCH_PRECHARGE_N_N);

	localparam logic [9:0] DAC_MID = 10'h200;
	localparam logic [9:0] DAC_LOW_DEF = 10'h123;
	localparam logic [9:0] DAC_HIGH_DEF = 10'h143;
	localparam logic [7:0] CHSEL_DEF = 8'h08;
	localparam int DUMMY_COMPARES = 10;
	localparam int CHECK_STEPS = 11;
	localparam int STEP_LOW_CHECK = 6;

	// Timing
	localparam int PCLK_NS = 50;
	localparam int TCK_NS = 400;
	localparam int TCK_HALF = TCK_NS / PCLK_NS / 2;
	localparam int CONV_WAIT_NS = 200;
	localparam int CONV_WAIT_CYC = (CONV_WAIT_NS + PCLK_NS - 1) / PCLK_NS;

	typedef enum logic [1:0] {
		BSADC_PRELOAD = 2'h1,
		BSADC_EXTEST = 2'h2
	} bsadc_instr_t;

	// APB register offsets of the tester
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LOW = 8'h04;
	localparam logic [7:0] REG_HIGH = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;

	// Port A runs in reverse pin order along the chain
	function automatic int pin_cell(input int base, input int pin, input int kind, input logic reversed);
		pin_cell = base - CELLS_PER_PIN * (reversed ? (7 - pin) : pin) - kind;
	endfunction : pin_cell

endpackage : bsadc_pkg

// ==== bsadc_link_if.sv ====
// Serial test link between tester and device
`timescale 1ns/100ps
`default_nettype none
interface bsadc_link_if;
	logic tck;
	logic tdi;
	logic tdo;
	logic capture_req;
	logic shift_en;
	logic update_req;
	logic [1:0] instr;

	modport tester (output tck, output tdi, output capture_req, output shift_en, output update_req,
		output instr, input tdo);
	modport device (input tck, input tdi, input capture_req, input shift_en, input update_req,
		input instr, output tdo);
endinterface : bsadc_link_if
`default_nettype wire

// ==== bsadc_device.sv ====
// Device end: boundary-scan chain with converter and port cells
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Tester checks input between two limit codes
// - Tester makes channel pin input, no pull-up
// - Enabling converter runs ten discarded comparisons
// - Tester waits 200 ns after converter enable
// - Reference held at 0x200 while sampling
// - Instruction before each pattern; check shifted-out bits
// - Lower-limit pass reads comparator as 0
// - Upper-limit pass reads comparator as 1
// - Hold spans five patterns, bounding test clock
// - Bit 0 shifted in and out first
// - Pin order kept; port A reversed
// - Analog cells at top, bits 204 to 161
// - Reference, channel, negative-select cell positions fixed
// - Three cells per pin, descending positions
// - Port C pins 2..5 have no cells
// - Idle converter cells take recommended values
// - Exactly one negative-input source selected
module bsadc_device
	import bsadc_pkg::*;
#(
	parameter int LEN = CHAIN_LEN
) (
	input wire logic pclk,
	input wire logic presetn,
	bsadc_link_if.device link,
	input wire logic compare_in,
	input wire logic analog_compare_result,
	input wire logic program_entry_observe,
	input wire logic converter_enable_func,
	output logic converter_busy,
	output logic converter_enable,
	output logic [9:0] dac_code,
	output logic [7:0] input_channel_select,
	output logic [2:0] negative_input_select,
	output logic sample_hold,
	output logic latch_precharge_n,
	output logic mux_to_negative_input_enable,
	output logic bandgap_on_positive_input,
	output logic comparator_idle,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe,
	output logic [7:0] pa_pullup,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe,
	output logic [7:0] pc_pullup,
	output logic [PORTE_PINS-1:0] pe_out,
	output logic [PORTE_PINS-1:0] pe_oe,
	output logic [PORTE_PINS-1:0] pe_pullup
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for link and analog inputs
	logic [1:0] tck_sync;
	logic tck_d;
	logic [1:0] tdi_sync;
	logic [1:0] cap_sync;
	logic [1:0] sh_sync;
	logic [1:0] upd_sync;
	logic [1:0] instr_s1;
	logic [1:0] instr_s2;
	logic [1:0] instr_take;
	logic [1:0] comp_sync;
	logic [1:0] aco_sync;
	logic [1:0] prog_sync;
	logic [1:0] conv_sync;
	logic conv_d;
	logic tck_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_sync <= 2'h0;
			tck_d <= 1'b0;
			tdi_sync <= 2'h0;
			cap_sync <= 2'h0;
			sh_sync <= 2'h0;
			upd_sync <= 2'h0;
			instr_s1 <= 2'h0;
			instr_s2 <= 2'h0;
			instr_take <= 2'h0;
			comp_sync <= 2'h0;
			aco_sync <= 2'h0;
			prog_sync <= 2'h0;
			conv_sync <= 2'h0;
			conv_d <= 1'b0;
		end else begin
			tck_sync <= {tck_sync[0], link.tck};
			tck_d <= tck_sync[1];
			tdi_sync <= {tdi_sync[0], link.tdi};
			cap_sync <= {cap_sync[0], link.capture_req};
			sh_sync <= {sh_sync[0], link.shift_en};
			upd_sync <= {upd_sync[0], link.update_req};
			instr_s1 <= link.instr;
			instr_s2 <= instr_s1;
			// Two-bit code crosses unsynchronised; take it only once both samples agree
			if (instr_s1 == instr_s2) begin
				instr_take <= instr_s2;
			end
			comp_sync <= {comp_sync[0], compare_in};
			aco_sync <= {aco_sync[0], analog_compare_result};
			prog_sync <= {prog_sync[0], program_entry_observe};
			conv_sync <= {conv_sync[0], converter_enable_func};
			conv_d <= conv_sync[1];
		end
	end

	assign tck_rise = tck_sync[1] && !tck_d;

	////////////////////////////////////////////////////////////////////////
	// Shift, capture and update registers
	logic [LEN-1:0] chain;
	logic [LEN-1:0] upd_reg;
	logic [LEN-1:0] applied;
	logic [LEN-1:0] next_capture;
	logic extest;

	assign extest = (instr_take == BSADC_EXTEST);

	always_comb begin
		next_capture = applied;
		next_capture[BIT_COMP] = comp_sync[1];
		next_capture[BIT_ACO] = aco_sync[1];
		next_capture[BIT_PROG_OBS] = prog_sync[1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain <= '0;
		end else if (tck_rise) begin
			if (cap_sync[1]) begin
				chain <= next_capture;
			end else if (sh_sync[1]) begin
				chain <= {tdi_sync[1], chain[LEN-1:1]};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_reg <= IDLE_CELLS[LEN-1:0];
		end else if (tck_rise && upd_sync[1] && !cap_sync[1] && !sh_sync[1]) begin
			upd_reg <= chain;
		end
	end

	// Cells reach the analog side only under external test
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied <= IDLE_CELLS[LEN-1:0];
		end else begin
			applied <= extest ? upd_reg : IDLE_CELLS[LEN-1:0];
		end
	end

	assign link.tdo = chain[0];

	////////////////////////////////////////////////////////////////////////
	// Analog cell outputs, top of the chain
	assign comparator_idle = applied[BIT_COMP_IDLE];
	assign mux_to_negative_input_enable = applied[BIT_MUX_NEG];
	assign bandgap_on_positive_input = applied[BIT_BG_POS];
	assign converter_enable = applied[BIT_CONV_EN];
	assign dac_code = applied[BIT_DAC_MSB:BIT_DAC_LSB];
	assign sample_hold = applied[BIT_HOLD];
	assign input_channel_select = applied[BIT_CHSEL_MSB:BIT_CHSEL_LSB];
	assign negative_input_select = applied[BIT_NEG_MSB:BIT_NEG_LSB];
	assign latch_precharge_n = applied[BIT_LATCH_PRECHARGE_N_N];

	////////////////////////////////////////////////////////////////////////
	// Port pin cells: value, direction, pull-up in descending order
	genvar gp;
	generate
		for (gp = 0; gp < 8; gp++) begin : g_porta
			assign pa_out[gp] = applied[pin_cell(PORTA_BASE, gp, 0, 1'b1)];
			assign pa_oe[gp] = applied[pin_cell(PORTA_BASE, gp, 1, 1'b1)];
			assign pa_pullup[gp] = applied[pin_cell(PORTA_BASE, gp, 2, 1'b1)];
		end
		for (gp = 0; gp < 8; gp++) begin : g_portc
			if (gp >= PORTC_TAP_LO && gp <= PORTC_TAP_HI) begin : g_tap
				// These pins carry the test link itself
				assign pc_out[gp] = 1'b0;
				assign pc_oe[gp] = 1'b0;
				assign pc_pullup[gp] = 1'b0;
			end else begin : g_cell
				assign pc_out[gp] = applied[pin_cell(PORTC_BASE, gp, 0, 1'b0)];
				assign pc_oe[gp] = applied[pin_cell(PORTC_BASE, gp, 1, 1'b0)];
				assign pc_pullup[gp] = applied[pin_cell(PORTC_BASE, gp, 2, 1'b0)];
			end
		end
		for (gp = 0; gp < PORTE_PINS; gp++) begin : g_porte
			assign pe_out[gp] = applied[pin_cell(PORTE_BASE, gp, 0, 1'b0)];
			assign pe_oe[gp] = applied[pin_cell(PORTE_BASE, gp, 1, 1'b0)];
			assign pe_pullup[gp] = applied[pin_cell(PORTE_BASE, gp, 2, 1'b0)];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Discarded conversion on functional enable
	logic [3:0] dummy_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dummy_cnt <= 4'h0;
			converter_busy <= 1'b0;
		end else if (conv_sync[1] && !conv_d && !extest) begin
			dummy_cnt <= 4'(DUMMY_COMPARES - 1);
			converter_busy <= 1'b1;
		end else if (dummy_cnt != 4'h0) begin
			dummy_cnt <= dummy_cnt - 4'h1;
		end else begin
			converter_busy <= 1'b0;
		end
	end

endmodule : bsadc_device
`default_nettype wire

// ==== bsadc_tester.sv ====
// Tester end: APB-driven limit check over the scan link
`timescale 1ns/100ps
`default_nettype none
module bsadc_tester
	import bsadc_pkg::*;
#(
	parameter int LEN = CHAIN_LEN,
	parameter int CHANNEL = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	bsadc_link_if.tester link
);

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CAPT = 6'h02,
		ST_SHIFT = 6'h04,
		ST_UPD = 6'h08,
		ST_WAIT = 6'h10,
		ST_DONE = 6'h20
	} bsadc_state_t;

	logic [9:0] low_limit;
	logic [9:0] high_limit;
	logic start;
	logic busy;
	logic done;
	logic pass;
	logic comp_low;
	logic comp_high;
	bsadc_state_t state;
	logic [3:0] step;
	logic [7:0] bit_idx;
	logic [LEN-1:0] pattern;
	logic [LEN-1:0] shifted_out;
	logic [2:0] div_cnt;
	logic tck_fall;
	logic tck_rise;
	logic [1:0] tdo_sync;
	logic [2:0] wait_cnt;

	////////////////////////////////////////////////////////////////////////
	// APB slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			low_limit <= DAC_LOW_DEF;
			high_limit <= DAC_HIGH_DEF;
			start <= 1'b0;
		end else begin
			start <= 1'b0;
			pready <= psel && !penable && !pready;
			pslverr <= 1'b0;
			// Read data and error settle in setup so they stand with pready
			if (psel && !penable) begin
				prdata <= 32'h0;
				if (paddr == REG_LOW) begin
					prdata <= {22'h0, low_limit};
				end else if (paddr == REG_HIGH) begin
					prdata <= {22'h0, high_limit};
				end else if (paddr == REG_STATUS) begin
					prdata <= {27'h0, comp_high, comp_low, pass, done, busy};
				end else if (paddr != REG_CTRL) begin
					pslverr <= 1'b1;
				end
			end
			// Writes land only at the access edge that completes the transfer
			if (psel && penable && pready && pwrite) begin
				if (paddr == REG_CTRL) begin
					start <= pwdata[0] && !busy;
				end else if (paddr == REG_LOW) begin
					low_limit <= pwdata[9:0];
				end else if (paddr == REG_HIGH) begin
					high_limit <= pwdata[9:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Test clock divider; hold spans five patterns, so rate bounds hold time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 3'h0;
			link.tck <= 1'b0;
			tdo_sync <= 2'h0;
		end else begin
			div_cnt <= (div_cnt == 3'(2 * TCK_HALF - 1)) ? 3'h0 : div_cnt + 3'h1;
			link.tck <= (div_cnt < 3'(TCK_HALF));
			tdo_sync <= {tdo_sync[0], link.tdo};
		end
	end

	assign tck_rise = (div_cnt == 3'h0);
	assign tck_fall = (div_cnt == 3'(TCK_HALF));

	// One row of the check, channel pin left as plain input
	function automatic logic [LEN-1:0] row(input logic [3:0] s, input logic [9:0] lo, input logic [9:0] hi);
		logic [LEN-1:0] r;
		logic [9:0] dac;
		r = IDLE_CELLS[LEN-1:0];
		dac = DAC_MID;
		if (s == 4'h4 || s == 4'h5) begin
			dac = lo;
		end else if (s == 4'h9 || s == 4'hA) begin
			dac = hi;
		end
		r[BIT_CONV_EN] = 1'b1;
		r[BIT_DAC_MSB:BIT_DAC_LSB] = dac;
		r[BIT_CHSEL_MSB:BIT_CHSEL_LSB] = CHSEL_DEF;
		r[BIT_NEG_MSB:BIT_NEG_LSB] = 3'h0;
		r[BIT_MUX_NEG] = 1'b0;
		r[BIT_HOLD] = !(s == 4'h2 || s == 4'h7);
		r[BIT_LATCH_PRECHARGE_N_N] = !(s == 4'h5 || s == 4'hA);
		r[pin_cell(PORTA_BASE, CHANNEL, 0, 1'b1)] = 1'b0;
		r[pin_cell(PORTA_BASE, CHANNEL, 1, 1'b1)] = 1'b0;
		r[pin_cell(PORTA_BASE, CHANNEL, 2, 1'b1)] = 1'b0;
		row = r;
	endfunction : row

	////////////////////////////////////////////////////////////////////////
	// Sequencer: capture, shift, update per pattern
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			step <= 4'h0;
			bit_idx <= 8'h0;
			pattern <= '0;
			shifted_out <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			pass <= 1'b0;
			comp_low <= 1'b0;
			comp_high <= 1'b0;
			wait_cnt <= 3'h0;
			link.tdi <= 1'b0;
			link.capture_req <= 1'b0;
			link.shift_en <= 1'b0;
			link.update_req <= 1'b0;
			link.instr <= BSADC_PRELOAD;
		end else begin
			if (tck_rise && state == ST_SHIFT) begin
				shifted_out[bit_idx] <= tdo_sync[1];
			end
			case (state)
				ST_IDLE: begin
					if (start) begin
						busy <= 1'b1;
						done <= 1'b0;
						step <= 4'h1;
						state <= ST_CAPT;
						pattern <= row(4'h1, low_limit, high_limit);
						link.instr <= BSADC_PRELOAD;
					end
				end
				ST_CAPT: begin
					if (tck_fall) begin
						link.capture_req <= !link.capture_req;
						if (link.capture_req) begin
							link.shift_en <= 1'b1;
							link.tdi <= pattern[0];
							bit_idx <= 8'h0;
							state <= ST_SHIFT;
						end
					end
				end
				ST_SHIFT: begin
					if (tck_fall) begin
						if (bit_idx == 8'(LEN - 1)) begin
							link.shift_en <= 1'b0;
							link.update_req <= 1'b1;
							state <= ST_UPD;
						end else begin
							bit_idx <= bit_idx + 8'h1;
							link.tdi <= pattern[bit_idx + 8'h1];
						end
					end
				end
				ST_UPD: begin
					if (tck_fall) begin
						link.update_req <= 1'b0;
						if (step == 4'(STEP_LOW_CHECK)) begin
							comp_low <= shifted_out[BIT_COMP];
						end
						if (step == 4'(CHECK_STEPS)) begin
							comp_high <= shifted_out[BIT_COMP];
							pass <= !comp_low && shifted_out[BIT_COMP];
							state <= ST_DONE;
						end else begin
							step <= step + 4'h1;
							pattern <= row(step + 4'h1, low_limit, high_limit);
							link.instr <= BSADC_EXTEST;
							wait_cnt <= 3'(CONV_WAIT_CYC);
							state <= (step == 4'h2) ? ST_WAIT : ST_CAPT;
						end
					end
				end
				ST_WAIT: begin
					// Settling after the step 2 pattern, hold low, is applied
					if (wait_cnt != 3'h0) begin
						wait_cnt <= wait_cnt - 3'h1;
					end else begin
						state <= ST_CAPT;
					end
				end
				ST_DONE: begin
					busy <= 1'b0;
					done <= 1'b1;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule : bsadc_tester
`default_nettype wire

// ==== bsadc_properties.sv ====
// Concurrent checks on the scan link, the converter cell outputs and the port C tap pin outputs
`timescale 1ns/100ps
`default_nettype none
module bsadc_properties
	import bsadc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tck,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic capture_req,
	input wire logic shift_en,
	input wire logic update_req,
	input wire logic [1:0] instr,
	input wire logic converter_enable_func,
	input wire logic converter_busy,
	input wire logic [9:0] dac_code,
	input wire logic [7:0] input_channel_select,
	input wire logic sample_hold,
	input wire logic latch_precharge_n,
	input wire logic [7:0] pc_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////
	// Link timing
	AST_TDO_AFTER_TCK_RISE: assert property ($changed(tdo) |-> $past(tck, 2) || $past(tck, 3))
		else $error("tdo moved without a recent tck rise");
	AST_TDI_WHILE_TCK_LOW: assert property ($changed(tdi) |-> !tck)
		else $error("tdi moved while tck high");
	AST_TCK_PERIOD: assert property ($rose(tck) |-> tck[*4] ##1 !tck[*4])
		else $error("tck period not eight cycles");
	AST_CONTROLS_EXCLUSIVE: assert property ($onehot0({capture_req, shift_en, update_req}))
		else $error("more than one scan control active");

	////////////////////////////////////////////////////////////////
	// Converter cells and port C tap pins
	AST_SAMPLE_AT_MIDSCALE: assert property (!sample_hold |-> dac_code == DAC_MID)
		else $error("reference not mid-scale while sampling");
	AST_PRECHARGE_WITH_LIMIT: assert property (!latch_precharge_n |-> sample_hold && dac_code != DAC_MID)
		else $error("precharge without hold and limit code");
	AST_ONE_CHANNEL: assert property ($onehot(input_channel_select))
		else $error("channel select not one-hot");
	// Sync depth plus update settle well inside six cycles
	AST_IDLE_OUTSIDE_EXTEST: assert property ((instr != BSADC_EXTEST)[*6] |-> sample_hold && latch_precharge_n
		&& dac_code == 10'h000 && input_channel_select == 8'h01)
		else $error("converter cells not idle outside extest");
	AST_BUSY_FOLLOWS_ENABLE: assert property ($rose(converter_enable_func) && instr != BSADC_EXTEST
		|-> ##[1:4] $rose(converter_busy))
		else $error("no dummy conversion after enable");
	AST_DUMMY_LENGTH: assert property ($rose(converter_busy)
		|-> converter_busy[*8] ##1 converter_busy ##1 converter_busy ##[1:2] !converter_busy)
		else $error("dummy conversion length wrong");
	AST_PORTC_TAP_PINS: assert property (pc_oe[5:2] == 4'h0)
		else $error("tap pins driven from chain");
endmodule : bsadc_properties
`default_nettype wire

// ==== boundary_scan_chain_adc_check_tb.sv ====
// Testbench: tester and device joined over the scan link
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_chain_adc_check_tb import bsadc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, compare_in, analog_compare_result;
	logic program_entry_observe, converter_enable_func, converter_busy, converter_enable, sample_hold, latch_precharge_n;
	logic [7:0] paddr, input_channel_select, pa_oe, pa_pullup, pc_oe;
	logic [9:0] dac_code, vin, lo, hi;
	logic [31:0] pwdata, prdata;
	logic [11:0] seen[$];
	int checks, miscompares, cycles;
	int dsel[11] = '{0, 0, 0, 1, 1, 0, 0, 0, 2, 2, 0};
	bit hpat[11] = '{1, 0, 1, 1, 1, 1, 0, 1, 1, 1, 1};
	bit ppat[11] = '{1, 1, 1, 1, 0, 1, 1, 1, 1, 0, 1};

	bsadc_link_if link();
	bsadc_tester bsadc_tester_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.tester));
	bsadc_device bsadc_device_inst(.pclk(pclk), .presetn(presetn), .link(link.device), .compare_in(compare_in),
		.analog_compare_result(analog_compare_result), .program_entry_observe(program_entry_observe),
		.converter_enable_func(converter_enable_func), .converter_busy(converter_busy),
		.converter_enable(converter_enable), .dac_code(dac_code), .input_channel_select(input_channel_select),
		.negative_input_select(), .sample_hold(sample_hold), .latch_precharge_n(latch_precharge_n),
		.mux_to_negative_input_enable(), .bandgap_on_positive_input(), .comparator_idle(), .pa_out(),
		.pa_oe(pa_oe), .pa_pullup(pa_pullup), .pc_out(), .pc_oe(pc_oe), .pc_pullup(), .pe_out(), .pe_oe(),
		.pe_pullup());
	bsadc_properties bsadc_properties_inst(.pclk(pclk), .presetn(presetn), .tck(link.tck), .tdi(link.tdi),
		.tdo(link.tdo), .capture_req(link.capture_req), .shift_en(link.shift_en), .update_req(link.update_req),
		.instr(link.instr), .converter_enable_func(converter_enable_func), .converter_busy(converter_busy),
		.dac_code(dac_code), .input_channel_select(input_channel_select), .sample_hold(sample_hold),
		.latch_precharge_n(latch_precharge_n), .pc_oe(pc_oe));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// Status expected from the limits: comparator high when the code is above the input
	function automatic logic [4:0] exp_status(input logic [9:0] l, input logic [9:0] h, input logic [9:0] v);
		exp_status = {h > v, l > v, (h > v) && !(l > v), 2'b10};
	endfunction : exp_status

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	////////////////////////////////////////////////////////////////
	// Comparator stand-in: latches only while precharge is low
	always @(posedge pclk) begin
		if (latch_precharge_n === 1'b0) begin
			compare_in <= dac_code > vin;
		end
	end

	// Record each change of cell setting applied under extest
	always @(posedge pclk) begin
		if (converter_enable === 1'b1 && (seen.size() == 0
			|| seen[$] !== {dac_code, sample_hold, latch_precharge_n})) begin
			seen.push_back({dac_code, sample_hold, latch_precharge_n});
			chk({pa_oe[3], pa_pullup[3], input_channel_select}, 32'h008);
		end
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic run();
		logic [31:0] r;
		logic e;
		apb(REG_LOW, 1'b1, {22'h0, lo}, r, e);
		apb(REG_HIGH, 1'b1, {22'h0, hi}, r, e);
		seen.delete();
		apb(REG_CTRL, 1'b1, 32'h1, r, e);
		// Second start lands while busy and must be ignored
		apb(REG_CTRL, 1'b1, 32'h1, r, e);
		r = 32'h0;
		while (r[1:0] !== 2'b10) apb(REG_STATUS, 1'b0, 32'h0, r, e);
		chk(r[4:0], exp_status(lo, hi, vin));
		chk(seen.size(), 11);
		for (int i = 0; i < 11 && i < seen.size(); i++) begin
			chk(seen[i], {dsel[i] == 0 ? DAC_MID : dsel[i] == 1 ? lo : hi, hpat[i], ppat[i]});
		end
	endtask : run

	initial begin
		logic [31:0] r;
		logic e;
		int n;
		r = $urandom(32'h8B4BF10B);
		{presetn, psel, penable, pwrite, compare_in, converter_enable_func} = 6'h00;
		{analog_compare_result, program_entry_observe} = 2'b10;
		paddr = 8'h00;
		pwdata = 32'h0;
		vin = 10'h000;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(REG_LOW, 1'b0, 32'h0, r, e);
		chk(r, 32'h123);
		apb(REG_HIGH, 1'b0, 32'h0, r, e);
		chk(r, 32'h143);
		apb(8'h10, 1'b0, 32'h0, r, e);
		chk(e, 1'b1);
		converter_enable_func <= 1'b1;
		while (converter_busy !== 1'b1) @(posedge pclk);
		n = 0;
		while (converter_busy === 1'b1) begin
			@(posedge pclk);
			n++;
		end
		chk(n >= DUMMY_COMPARES && n <= DUMMY_COMPARES + 1, 1'b1);
		converter_enable_func <= 1'b0;
		// Pass at the lower bound, random point, fail at the upper bound
		for (int k = 0; k < 3; k++) begin
			analog_compare_result <= 1'($urandom);
			program_entry_observe <= 1'($urandom);
			lo = k == 0 ? DAC_LOW_DEF : 10'($urandom_range(700, 16));
			// A limit at mid-scale would hide its step in the cell trace
			if (lo == DAC_MID) lo = lo + 10'h1;
			hi = k == 0 ? DAC_HIGH_DEF : lo + 10'($urandom_range(200, 1));
			if (hi == DAC_MID) hi = hi + 10'h1;
			vin <= k == 0 ? lo : k == 1 ? 10'($urandom) : hi;
			run();
		end
		conclude();
	end
endmodule : boundary_scan_chain_adc_check_tb
`default_nettype wire
